// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import uif_pkg::*;
    logic ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata_r, r;
    logic [5:0] otg_cmd = 6'h00, otg_status_in;
    logic [1:0] ls_cmd = 2'h3, rx_cmd = 2'h0, line_state;
    logic rx_diff_in, rx_minus_in, rx_plus_in, tx_se0_r, tx_data_r, transmit_enable_low_r;
    logic serial_interface_select_r, rx_active, rx_error, rx_endp_stb_r, power_signal_valid_r;
    logic pkt_start = 1'b0, pid_valid = 1'b0, tok_valid = 1'b0, tok_crc5_ok = 1'b0;
    logic tok_pid_ok = 1'b0, data_crc16_fail = 1'b0, sof_pulse = 1'b0;
    logic [3:0] pid_value = 4'h0, tok_endp = 4'h0, ep = 4'h0, v;
    logic [6:0] tok_addr = 7'h00, dev_addr = 7'h00, fl;
    logic [NPORT-1:0] flag_port_r;
    logic [4:0] rx_endp_r;
    logic [7:0] power_signal_value_r;
    logic [15:0] mk;
    logic [10:0] sv;
    logic [7:0] rz [11] = '{OFS_FLG, OFS_HLD, OFS_MSK, OFS_SOF, OFS_PID, OFS_EPT, OFS_MRK,
        OFS_OTM, OFS_PWR, 8'h40, 8'h00};
    int n_errors = 0, n_checks = 0, n, n_stb = 0, s0;
    logic [4:0] endp_seen = 5'h00;

    uif_status_flags DUT (.ref_clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata_r, .otg_status_in, .rx_diff_in, .rx_minus_in, .rx_plus_in, .tx_se0_r,
        .tx_data_r, .transmit_enable_low_r, .serial_interface_select_r, .line_state,
        .rx_active, .rx_error, .pkt_start, .pid_valid, .pid_value, .tok_valid, .tok_crc5_ok,
        .tok_pid_ok, .tok_addr, .tok_endp, .dev_addr, .data_crc16_fail, .sof_pulse,
        .flag_port_r, .rx_endp_r, .rx_endp_stb_r, .power_signal_valid_r,
        .power_signal_value_r);
    uif_xcvr_model xcvr (.ref_clk, .otg_cmd, .ls_cmd, .rx_cmd, .tx_se0_r, .tx_data_r,
        .transmit_enable_low_r, .otg_status_in, .rx_diff_in, .rx_minus_in, .rx_plus_in,
        .line_state, .rx_active, .rx_error);

    always #10 ref_clk = ~ref_clk;

    // The endpoint strobe stands one cycle only, so it is counted on the edge that sees it
    always @(posedge ref_clk) begin
        if (rx_endp_stb_r === 1'b1) begin
            n_stb <= n_stb + 1;
            endp_seen <= rx_endp_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Expected serial readback, using the loopback the transceiver model applies
    function automatic logic [31:0] exp_ser(input logic [3:0] c);
        if (!c[1]) begin
            return {25'h0, c[2], ~c[2] & ~c[3], c[2] & ~c[3], c};
        end
        return {25'h0, 3'b101, c};
    endfunction : exp_ser

    // Expected port levels; bit 7 of each mask field selects nothing
    function automatic logic [NPORT-1:0] exp_port(input logic [31:0] m, input logic [6:0] f);
        for (int k = 0; k < NPORT; k++) begin
            exp_port[k] = |(m[8*k +: 7] & f);
        end
    endfunction : exp_port

    ////////////////////////////////////////////////////////////////////////////////////////
    // Tasks start and end just after a rising edge
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    // Read data is registered, so it is settled one edge after the strobe is taken
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        chk(reg_rdata_r, exp);
    endtask : rdc

    task automatic pkt;
        pkt_start <= 1'b1;
        @(posedge ref_clk);
        pkt_start <= 1'b0;
        @(posedge ref_clk);
    endtask : pkt

    // One-cycle cause for flag k; 7 is a foreign address, 8 a bad checksum
    task automatic ev(input int k);
        case (k)
            8: {tok_valid, tok_crc5_ok, tok_pid_ok, tok_addr, tok_endp} <= {3'b101, dev_addr, ep};
            7: {tok_valid, tok_crc5_ok, tok_pid_ok, tok_addr, tok_endp} <=
                {3'b111, dev_addr ^ 7'h01, ep};
            6: {tok_valid, tok_crc5_ok, tok_pid_ok, tok_addr, tok_endp} <= {3'b111, dev_addr, ep};
            5: ls_cmd <= LS_SE0;
            4: ls_cmd <= LS_K;
            3: ls_cmd <= LS_J;
            2: data_crc16_fail <= 1'b1;
            default: rx_cmd[k[0]] <= 1'b1;
        endcase
        @(posedge ref_clk);
        tok_valid <= 1'b0;
        ls_cmd <= 2'h3;
        data_crc16_fail <= 1'b0;
        rx_cmd <= 2'h0;
        @(posedge ref_clk);
    endtask : ev

    task automatic conclude;
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////////////
    // Watchdog: a hang counts as a mismatch
    initial begin
        #2000000;
        n_errors++;
        conclude();
    end

    initial begin
        void'($urandom(96));
        tick(20);
        resetn <= 1'b1;
        // Synchronised receive lines need two edges after release
        tick(2);
        chk(32'(transmit_enable_low_r), 32'h1);
        rdc(OFS_SER, exp_ser(4'h2));
        foreach (rz[i]) rdc(rz[i], 32'h0);
        // Serial controls, SE0 while transmitting first
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 4'h8 : 4'($urandom);
            wr(OFS_SER, {28'hfff_fff7, v});
            tick(3);
            r = 32'({tx_se0_r, tx_data_r, transmit_enable_low_r, serial_interface_select_r});
            chk(r, 32'(v));
            rdc(OFS_SER, exp_ser(v));
        end
        wr(OFS_SER, 32'h2);
        repeat (4) begin
            otg_cmd <= 6'($urandom);
            wr(OFS_OTG, 32'hffff_ffff);
            tick(2);
            rdc(OFS_OTG, {26'h0, otg_cmd});
        end
        rx_cmd <= 2'h3;
        tick(3);
        rdc(OFS_FLG, 32'h3);
        rx_cmd <= 2'h0;
        tick(3);
        rdc(OFS_FLG, 32'h0);
        for (int k = 2; k < 7; k++) begin
            ev(k);
            tick(2);
            rdc(OFS_FLG, 32'h1 << k);
            pkt();
            rdc(OFS_FLG, 32'h0);
        end
        // Held flags against random masks; first pass checks the unused mask bits
        wr(OFS_HLD, 32'h7f);
        for (int i = 0; i < 5; i++) begin
            fl = (i == 0) ? 7'h7f : 7'($urandom);
            r = (i == 0) ? 32'h8080_8080 : $urandom;
            for (int k = 0; k < 7; k++) begin
                if (fl[k]) ev(k);
            end
            tick(2);
            pkt();
            rdc(OFS_FLG, {25'h0, fl});
            wr(OFS_MSK, r);
            tick(1);
            chk(32'(flag_port_r), 32'(exp_port(r, fl)));
            wr(OFS_FLG, {25'h0, fl});
            rdc(OFS_FLG, 32'h0);
        end
        // Tokens: foreign address and bad checksum give no hit
        dev_addr <= 7'($urandom);
        mk = 16'($urandom);
        wr(OFS_MRK, {16'hffff, mk});
        wr(OFS_HLD, 32'h0);
        repeat (4) begin
            ep = 4'($urandom);
            s0 = n_stb;
            ev(8);
            ev(7);
            rdc(OFS_FLG, 32'h0);
            ev(6);
            n = 0;
            while (n_stb == s0 && n < 4) begin
                tick(1);
                n++;
            end
            chk(32'(n_stb - s0), 32'h1);
            chk({27'h0, endp_seen}, {27'h0, mk[ep], ep});
            rdc(OFS_EPT, {27'h0, 1'b1, ep});
            rdc(OFS_FLG, 32'h40);
            pkt();
        end
        // Frame counter, wrap from the top value first
        for (int i = 0; i < 3; i++) begin
            sv = (i == 0) ? 11'h7ff : 11'($urandom);
            n = 1 + int'($urandom % 5);
            wr(OFS_SOF, {21'h1f_ffff, sv});
            sof_pulse <= 1'b1;
            tick(n);
            sof_pulse <= 1'b0;
            rdc(OFS_SOF, {21'h0, 11'(sv + 11'(n))});
        end
        repeat (3) begin
            ep = 4'($urandom);
            pid_value <= ep;
            pid_valid <= 1'b1;
            tick(1);
            pid_valid <= 1'b0;
            wr(OFS_PID, 32'hffff_ffff);
            rdc(OFS_PID, {28'h0, ep});
        end
        r = $urandom;
        wr(OFS_PWR, r);
        chk(32'({power_signal_valid_r, power_signal_value_r}), 32'(r[8:0]));
        rdc(OFS_PWR, 32'(r[8:0]));
        wr(OFS_OTM, ~r);
        rdc(OFS_OTM, ~r);
        conclude();
    end
endmodule : tb_top
`default_nettype wire

// >>> uif_pkg.sv
`default_nettype none
package uif_pkg;
    // Register offsets
    localparam logic [7:0] OFS_OTG = 8'h14;
    localparam logic [7:0] OFS_SER = 8'h18;
    localparam logic [7:0] OFS_FLG = 8'h1c;
    localparam logic [7:0] OFS_HLD = 8'h20;
    localparam logic [7:0] OFS_MSK = 8'h24;
    localparam logic [7:0] OFS_SOF = 8'h28;
    localparam logic [7:0] OFS_PID = 8'h2c;
    localparam logic [7:0] OFS_EPT = 8'h30;
    localparam logic [7:0] OFS_MRK = 8'h34;
    localparam logic [7:0] OFS_OTM = 8'h38;
    localparam logic [7:0] OFS_PWR = 8'h3c;
    // Serial control field positions
    localparam int SER_RCV = 6;
    localparam int SER_RXM = 5;
    localparam int SER_RXP = 4;
    localparam int SER_SE0 = 3;
    localparam int SER_TXD = 2;
    localparam int SER_TXEN = 1;
    localparam int SER_FSLS = 0;
    // Signal flag positions
    localparam int FLG_TOK = 6;
    localparam int FLG_SE0 = 5;
    localparam int FLG_K = 4;
    localparam int FLG_J = 3;
    localparam int FLG_CRC = 2;
    localparam int FLG_RXA = 1;
    localparam int FLG_RXE = 0;
    localparam int NFLG = 7;
    // Other field positions, mask field width and port count
    localparam int EP_VALID = 4;
    localparam int PWR_VALID = 8;
    localparam int MSK_W = 8;
    localparam int NPORT = 4;
    // Reset values
    localparam logic SER_TXEN_RST = 1'b1;
    localparam logic [6:0] FLG_RST = 7'h00;
    localparam logic [31:0] MSK_RST = 32'h0000_0000;
    localparam logic [10:0] SOF_RST = 11'h000;
    localparam logic [15:0] MRK_RST = 16'h0000;
    localparam logic [31:0] OTM_RST = 32'h0000_0000;
    localparam logic [8:0] PWR_RST = 9'h000;
    // Line state codes and endpoint mark bit
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J = 2'h1;
    localparam logic [1:0] LS_K = 2'h2;
    localparam logic [4:0] EP_MARK_OR = 5'h10;
endpackage : uif_pkg
`default_nettype wire

// >>> uif_status_flags.sv
`timescale 1ns/10ps
`default_nettype none
module uif_status_flags
    import uif_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata_r,
    input wire logic [5:0] otg_status_in,
    input wire logic rx_diff_in,
    input wire logic rx_minus_in,
    input wire logic rx_plus_in,
    output logic tx_se0_r,
    output logic tx_data_r,
    output logic transmit_enable_low_r,
    output logic serial_interface_select_r,
    input wire logic [1:0] line_state,
    input wire logic rx_active,
    input wire logic rx_error,
    input wire logic pkt_start,
    input wire logic pid_valid,
    input wire logic [3:0] pid_value,
    input wire logic tok_valid,
    input wire logic tok_crc5_ok,
    input wire logic tok_pid_ok,
    input wire logic [6:0] tok_addr,
    input wire logic [3:0] tok_endp,
    input wire logic [6:0] dev_addr,
    input wire logic data_crc16_fail,
    input wire logic sof_pulse,
    output logic [NPORT-1:0] flag_port_r,
    output logic [4:0] rx_endp_r,
    output logic rx_endp_stb_r,
    output logic power_signal_valid_r,
    output logic [7:0] power_signal_value_r
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers

    logic [8:0] async_in;
    logic [8:0] meta_r;
    logic [8:0] sync_r;
    genvar gs;

    // Transceiver status lines are not tied to ref_clk, so each bit is resynced
    assign async_in = {rx_diff_in, rx_minus_in, rx_plus_in, otg_status_in};

    generate
        for (gs = 0; gs < 9; gs++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    meta_r[gs] <= 1'b0;
                    sync_r[gs] <= 1'b0;
                end else begin
                    meta_r[gs] <= async_in[gs];
                    sync_r[gs] <= meta_r[gs];
                end
            end
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////
// Register decode

    logic [NFLG-1:0] flags_r;
    logic [NFLG-1:0] flags_nxt;
    logic [NFLG-1:0] hold_r;
    logic [31:0] mask_r;
    logic [10:0] sof_cnt_r;
    logic [3:0] pid_r;
    logic [3:0] endp_r;
    logic endp_valid_r;
    logic [15:0] mark_r;
    logic [31:0] otg_mask_r;
    logic [31:0] rdata_nxt;
    logic wr_ser;
    logic wr_flg;
    logic wr_hld;
    logic wr_msk;
    logic wr_sof;
    logic wr_mrk;
    logic wr_otm;
    logic wr_pwr;
    logic [NFLG-1:0] flg_clr;
    logic tok_hit;
    logic [NFLG-1:0] flg_ev;
    logic [6:0] ser_view;

    // Write strobes per register
    assign wr_ser = reg_wr && (reg_addr == OFS_SER);
    assign wr_flg = reg_wr && (reg_addr == OFS_FLG);
    assign wr_hld = reg_wr && (reg_addr == OFS_HLD);
    assign wr_msk = reg_wr && (reg_addr == OFS_MSK);
    assign wr_sof = reg_wr && (reg_addr == OFS_SOF);
    assign wr_mrk = reg_wr && (reg_addr == OFS_MRK);
    assign wr_otm = reg_wr && (reg_addr == OFS_OTM);
    assign wr_pwr = reg_wr && (reg_addr == OFS_PWR);
    assign flg_clr = wr_flg ? reg_wdata[NFLG-1:0] : '0;

    assign ser_view = {sync_r[8:6], tx_se0_r, tx_data_r,
        transmit_enable_low_r, serial_interface_select_r};

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (reg_addr)
            OFS_OTG: rdata_nxt = {26'h0, sync_r[5:0]};
            OFS_SER: rdata_nxt = {25'h0, ser_view};
            OFS_FLG: rdata_nxt = {25'h0, flags_r};
            OFS_HLD: rdata_nxt = {25'h0, hold_r};
            OFS_MSK: rdata_nxt = mask_r;
            OFS_SOF: rdata_nxt = {21'h0, sof_cnt_r};
            OFS_PID: rdata_nxt = {28'h0, pid_r};
            OFS_EPT: rdata_nxt = {27'h0, endp_valid_r, endp_r};
            OFS_MRK: rdata_nxt = {16'h0, mark_r};
            OFS_OTM: rdata_nxt = otg_mask_r;
            OFS_PWR: rdata_nxt = {23'h0, power_signal_valid_r,
                power_signal_value_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data is held until the next read
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata_r <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata_r <= rdata_nxt;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Serial line control and plain storage

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            tx_se0_r <= 1'b0;
            tx_data_r <= 1'b0;
            transmit_enable_low_r <= SER_TXEN_RST;
            serial_interface_select_r <= 1'b0;
        end else if (wr_ser) begin
            tx_se0_r <= reg_wdata[SER_SE0];
            tx_data_r <= reg_wdata[SER_TXD];
            transmit_enable_low_r <= reg_wdata[SER_TXEN];
            serial_interface_select_r <= reg_wdata[SER_FSLS];
        end
    end

    // Configuration registers written whole
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            hold_r <= FLG_RST;
            mask_r <= MSK_RST;
            mark_r <= MRK_RST;
            otg_mask_r <= OTM_RST;
            {power_signal_valid_r, power_signal_value_r} <= PWR_RST;
        end else begin
            if (wr_hld) hold_r <= reg_wdata[NFLG-1:0];
            if (wr_msk) mask_r <= reg_wdata;
            if (wr_mrk) mark_r <= reg_wdata[15:0];
            if (wr_otm) otg_mask_r <= reg_wdata;
            if (wr_pwr) begin
                power_signal_valid_r <= reg_wdata[PWR_VALID];
                power_signal_value_r <= reg_wdata[7:0];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Signal flags

    // A token counts only with both checks good and our own address
    assign tok_hit = tok_valid && tok_crc5_ok && tok_pid_ok
        && (tok_addr == dev_addr);

    assign flg_ev[FLG_TOK] = tok_hit;
    assign flg_ev[FLG_SE0] = (line_state == LS_SE0);
    assign flg_ev[FLG_K] = (line_state == LS_K);
    assign flg_ev[FLG_J] = (line_state == LS_J);
    assign flg_ev[FLG_CRC] = data_crc16_fail;
    assign flg_ev[FLG_RXA] = rx_active;
    assign flg_ev[FLG_RXE] = rx_error;

    // Per flag: a set in the clearing cycle wins over the clear
    genvar gf;
    generate
        for (gf = 0; gf < NFLG; gf++) begin : g_flag
            logic kept;
            assign kept = (flags_r[gf] & ~flg_clr[gf]) | flg_ev[gf];
            if (gf < 2) begin : g_lvl
                assign flags_nxt[gf] = hold_r[gf] ? kept
                    : flg_ev[gf];
            end else begin : g_evt
                assign flags_nxt[gf] = hold_r[gf] ? kept
                    : (pkt_start ? flg_ev[gf] : kept);
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            flags_r <= FLG_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Flag ports

    // Ports lag the flags by one cycle to keep outputs on flip-flops
    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            logic any_sel;
            assign any_sel = |(flags_r & mask_r[gp*MSK_W +: NFLG]);
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    flag_port_r[gp] <= 1'b0;
                end else begin
                    flag_port_r[gp] <= any_sel;
                end
            end
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////
// Frame counter, packet and endpoint capture

    // Software load wins over a frame pulse in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sof_cnt_r <= SOF_RST;
        end else if (wr_sof) begin
            sof_cnt_r <= reg_wdata[10:0];
        end else if (sof_pulse) begin
            sof_cnt_r <= sof_cnt_r + 11'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pid_r <= 4'h0;
        end else if (pid_valid) begin
            pid_r <= pid_value;
        end
    end

    // Endpoint is only taken from tokens meant for this device
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            endp_r <= 4'h0;
            endp_valid_r <= 1'b0;
            rx_endp_r <= 5'h00;
            rx_endp_stb_r <= 1'b0;
        end else begin
            rx_endp_stb_r <= tok_hit;
            if (tok_hit) begin
                endp_r <= tok_endp;
                endp_valid_r <= 1'b1;
                rx_endp_r <= {1'b0, tok_endp}
                    | (mark_r[tok_endp] ? EP_MARK_OR : 5'h00);
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Assertions

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    otg_mirror_a: assert property (reg_rd && reg_addr == OFS_OTG
        |=> reg_rdata_r == {26'h0, $past(sync_r[5:0])})
        else $error("OTG status read does not mirror inputs");
    ser_rx_a: assert property (reg_rd && reg_addr == OFS_SER
        |=> reg_rdata_r[6:4] == $past(sync_r[8:6]))
        else $error("Serial receive bits wrong");
    ser_tx_a: assert property (wr_ser ##1 !wr_ser
        |-> {tx_se0_r, tx_data_r} == $past(reg_wdata[3:2], 1))
        else $error("Serial transmit bits not written");
    txen_low_a: assert property (wr_ser
        |=> transmit_enable_low_r == $past(reg_wdata[SER_TXEN]))
        else $error("Transmit enable low not written");
    fsls_sel_a: assert property (wr_ser
        |=> serial_interface_select_r == $past(reg_wdata[SER_FSLS]))
        else $error("Serial mode select not written");
    pkt_clear_a: assert property (pkt_start && !hold_r[FLG_CRC]
        && !data_crc16_fail |=> !flags_r[FLG_CRC])
        else $error("Non-held flag survived packet start");
    token_set_a: assert property (tok_hit
        |=> flags_r[FLG_TOK])
        else $error("Token flag not set");
    // A held flag may still drop by a write-one clear issued in the cycle before
    line_se0_a: assert property (line_state == LS_SE0
        |=> flags_r[FLG_SE0] ##1 (flags_r[FLG_SE0] || !$past(hold_r[FLG_SE0])
        || $past(flg_clr[FLG_SE0])))
        else $error("SE0 flag not set");
    crc_fail_a: assert property (data_crc16_fail
        |=> flags_r[FLG_CRC])
        else $error("CRC16 flag not set");
    rx_track_a: assert property (!hold_r[FLG_RXA]
        |=> flags_r[FLG_RXA] == $past(rx_active))
        else $error("Receive active flag not tracking");
    held_flag_a: assert property (flags_r[FLG_J] && hold_r[FLG_J]
        && !flg_clr[FLG_J] |=> flags_r[FLG_J])
        else $error("Held flag dropped");
    port_or_a: assert property ((flags_r[0] && mask_r[0])
        |=> flag_port_r[0])
        else $error("Port a not raised by selected flag");
    port_d_a: assert property ((flags_r[1] && mask_r[25])
        |=> flag_port_r[3])
        else $error("Fourth port not raised");
    sof_step_a: assert property (sof_pulse && !wr_sof
        |=> sof_cnt_r == $past(sof_cnt_r) + 11'h001)
        else $error("Frame counter did not advance");
    pid_cap_a: assert property (pid_valid
        |=> pid_r == $past(pid_value))
        else $error("Packet identifier not captured");
    endp_cap_a: assert property (tok_hit
        |=> endp_valid_r && endp_r == $past(tok_endp))
        else $error("Endpoint not captured");
    endp_mark_a: assert property (tok_hit
        |=> rx_endp_stb_r && rx_endp_r[4] == $past(mark_r[tok_endp]))
        else $error("Endpoint mark not applied");
    addr_gate_a: assert property (tok_valid && tok_addr != dev_addr
        |=> !rx_endp_stb_r && !$changed(endp_r))
        else $error("Foreign token passed on");

    tok_seen_c: cover property (tok_hit ##1 rx_endp_r[4]);
    held_clr_c: cover property (hold_r[FLG_CRC] && flags_r[FLG_CRC]
        && flg_clr[FLG_CRC]);
    port_hi_c: cover property (flag_port_r[2]);
    sof_wrap_c: cover property (sof_pulse && sof_cnt_r == 11'h7ff);

endmodule : uif_status_flags
`default_nettype wire

// >>> uif_xcvr_model.sv
`timescale 1ns/10ps
`default_nettype none
module uif_xcvr_model (
    input wire logic ref_clk,
    input wire logic [5:0] otg_cmd,
    input wire logic [1:0] ls_cmd,
    input wire logic [1:0] rx_cmd,
    input wire logic tx_se0_r,
    input wire logic tx_data_r,
    input wire logic transmit_enable_low_r,
    output logic [5:0] otg_status_in,
    output logic rx_diff_in,
    output logic rx_minus_in,
    output logic rx_plus_in,
    output logic [1:0] line_state,
    output logic rx_active,
    output logic rx_error
);
    ////////////////////////////////////////////////////////////////////////////////////////
    // Status levels follow the bench's commands one edge late, as a registered PHY would
    always_ff @(posedge ref_clk) begin
        otg_status_in <= otg_cmd;
        line_state <= ls_cmd;
        rx_active <= rx_cmd[1];
        rx_error <= rx_cmd[0];
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    // Receivers hear our own transmit; bus idles at J when the driver is off
    always_ff @(posedge ref_clk) begin
        if (!transmit_enable_low_r) begin
            rx_plus_in <= tx_data_r & ~tx_se0_r;
            rx_minus_in <= ~tx_data_r & ~tx_se0_r;
            rx_diff_in <= tx_data_r;
        end else begin
            rx_plus_in <= 1'b1;
            rx_minus_in <= 1'b0;
            rx_diff_in <= 1'b1;
        end
    end
endmodule : uif_xcvr_model
`default_nettype wire
